//--- common/mmr_pkg.sv
// Constants, field layouts and carrier types of the relocation and protection unit.
// Assumes one processor clock and a core that issues one reference at a time.
package mmr_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_KERN_BASE = 8'h00;
  localparam logic [7:0] OFS_KERN_DESC = 8'h20;
  localparam logic [7:0] OFS_USER_BASE = 8'h40;
  localparam logic [7:0] OFS_USER_DESC = 8'h60;
  localparam logic [7:0] OFS_CONTROL   = 8'h80;
  localparam logic [7:0] OFS_STATUS    = 8'h84;
  localparam logic [7:0] OFS_FAULT     = 8'h88;

  localparam logic [15:0] RST_PAGE_REG = 16'h0000;
  localparam logic [15:0] RST_STATUS   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  localparam int BASE_LSB     = 0;
  localparam int BASE_W       = 12;
  localparam int KEY_LSB      = 1;
  localparam int KEY_W        = 2;
  localparam int CTL_RELOC    = 0;
  localparam int PS_CUR_LSB   = 14;
  localparam int PS_PREV_LSB  = 12;
  localparam int PS_PRI_LSB   = 5;
  localparam int PS_TRAP_BIT  = 4;
  localparam int PAGE_SEL_LSB = 13;
  localparam int BLOCK_SHIFT  = 6;

  localparam logic [1:0] MODE_KERNEL  = 2'h0;
  localparam logic [1:0] MODE_USER    = 2'h3;
  localparam logic [2:0] KEY_NONRES   = 3'h0;
  localparam logic [2:0] KEY_READONLY = 3'h2;
  localparam logic [2:0] KEY_FULL     = 3'h4;
  localparam logic [2:0] PRI_BOOT     = 3'h7;
  localparam logic [2:0] PRI_CLEAR    = 3'h0;
  localparam logic [2:0] IO_PAGE_SEL  = 3'h7;
  localparam logic [1:0] IO_PAGE_TOP  = 2'h3;

  // Cycles from reset release until the synchronised strap is settled.
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------------
  // Status word commands
  // ----------------------------------------------------------------------
  typedef enum logic [4:0] {
    PS_NONE     = 5'h01,
    PS_TRAP     = 5'h02,
    PS_RETURN   = 5'h04,
    PS_MOVE     = 5'h08,
    PS_EXPLICIT = 5'h10
  } mmr_ps_op_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        use_prev;
    logic [15:0] vaddr;
  } mmr_req_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic        nonres;
    logic        readonly;
    logic        io_page;
    logic [17:0] paddr;
  } mmr_rsp_t;

endpackage

//--- logic/mmr_top.sv
// Virtual to physical relocation, page protection, mode and stack pointer selection.
// Assumes an AXI4-Lite master for software and a core on the same clock.
//
// Overview of operation
// - Translate 16-bit virtual address to 18-bit physical via selected register pair.
// - Each mode has eight 8K-byte pages, each relocated separately.
// - Page base may sit on any 64-byte boundary.
// - Pages relocate independently; several may share memory with different rights.
// - Topmost 8K bytes of physical space is the peripheral register page.
// - Block is 64 bytes, every page a fixed 128 blocks with no length check, eight pages per mode.
// - Relocation constant comes straight from the page base register.
// - Access key 0 means non-resident; any access aborts at once.
// - Abort stops the instruction immediately; faulting reference never completes.
// - Key 2 allows reads and fetches, aborts any write.
// - Key 4 grants full read and write access.
// - Two full register sets; current or previous mode chooses between them.
// - Status bits 15:14 are current mode, selecting set for ordinary references.
// - Status bits 13:12 are previous mode, for cross-space instructions.
// - Trap or interrupt copies old current mode into previous mode.
// - Current mode clears at power-up, selecting kernel.
// - Mode 00 kernel, 11 user; 01 and 10 never abort.
// - Register six references use current mode stack pointer, relocation or not.
// - Kernel software may write the whole status word.
// - User return keeps priority and modes; move-to-status never changes current mode.
// - Power-up sets priority for bootstrap, clears it otherwise.
`timescale 1ns/1ps

module mmr_top (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0]         s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  // AXI4-Lite write response
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  // AXI4-Lite read
  input  wire logic [7:0]         s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready,
  // Core reference port
  input  wire mmr_pkg::mmr_req_t  core_req,
  output mmr_pkg::mmr_rsp_t       core_rsp_q,
  // Core status word port
  input  wire mmr_pkg::mmr_ps_op_t ps_op,
  input  wire logic [15:0]        ps_src,
  output logic [15:0]             ps_word_q,
  // Core stack pointer port
  input  wire logic               sp_we,
  input  wire logic [15:0]        sp_wdata,
  output logic [15:0]             sp_rdata_q,
  // Power-up start strap, high when starting the bootstrap
  input  wire logic               boot_strap
);

  // ----------------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------------
  // Codes 01 and 10 fall back to the kernel set instead of aborting.
  // mode codes never abort
  function automatic logic is_user(input logic [1:0] mode);
    is_user = (mode == mmr_pkg::MODE_USER);
  endfunction

  function automatic logic [2:0] key_of(input logic [15:0] desc);
    key_of = {desc[mmr_pkg::KEY_LSB +: mmr_pkg::KEY_W], 1'b0};
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] base_q [2][8];
  logic [15:0] desc_q [2][8];
  logic [15:0] sp_q [2];
  logic        reloc_en_q;
  logic [15:0] ps_q;
  logic [15:0] fault_va_q;
  logic [3:0]  fault_info_q;
  logic        strap_s1_q;
  logic        strap_s2_q;
  logic [1:0]  settle_q;
  logic        init_pending_q;

  logic [1:0]  cur_mode;
  logic [1:0]  prev_mode;
  assign cur_mode  = ps_q[mmr_pkg::PS_CUR_LSB +: 2];
  assign prev_mode = ps_q[mmr_pkg::PS_PREV_LSB +: 2];

  // ----------------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------------
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic        wr_page;
  logic        wr_hit;

  assign wr_fire = aw_got_q && w_got_q && !s_bvalid;
  assign wr_page = (aw_addr_q[1:0] == 2'h0) && (aw_addr_q[7] == 1'b0);
  assign wr_hit  = wr_page || (aw_addr_q == mmr_pkg::OFS_CONTROL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      s_awready <= 1'b0;
    end else begin
      s_awready <= !aw_got_q && !(s_awvalid && s_awready) && !s_bvalid;
      if (s_awvalid && s_awready) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_awaddr;
        s_awready <= 1'b0;
      end else if (wr_fire) begin
        aw_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q  <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_wready <= 1'b0;
    end else begin
      s_wready <= !w_got_q && !(s_wvalid && s_wready) && !s_bvalid;
      if (s_wvalid && s_wready) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_wdata;
        w_strb_q <= s_wstrb;
        s_wready <= 1'b0;
      end else if (wr_fire) begin
        w_got_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= mmr_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_bvalid <= 1'b1;
      s_bresp  <= wr_hit ? mmr_pkg::RESP_OKAY : mmr_pkg::RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Page register sets
  // ----------------------------------------------------------------------
  // two register sets
  for (genvar s = 0; s < 2; s++) begin : g_set
    for (genvar p = 0; p < 8; p++) begin : g_page
      logic hit_base;
      logic hit_desc;
      assign hit_base = wr_fire && wr_page && (aw_addr_q[6:5] == 2'(2 * s)) &&
                        (aw_addr_q[4:2] == 3'(p));
      assign hit_desc = wr_fire && wr_page && (aw_addr_q[6:5] == 2'(2 * s + 1)) &&
                        (aw_addr_q[4:2] == 3'(p));
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          base_q[s][p] <= mmr_pkg::RST_PAGE_REG;
          desc_q[s][p] <= mmr_pkg::RST_PAGE_REG;
        end else begin
          for (int b = 0; b < 2; b++) begin
            if (hit_base && w_strb_q[b]) begin
              base_q[s][p][8*b +: 8] <= w_data_q[8*b +: 8];
            end
            if (hit_desc && w_strb_q[b]) begin
              desc_q[s][p][8*b +: 8] <= w_data_q[8*b +: 8];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reloc_en_q <= 1'b0;
    end else if (wr_fire && (aw_addr_q == mmr_pkg::OFS_CONTROL) && w_strb_q[0]) begin
      reloc_en_q <= w_data_q[mmr_pkg::CTL_RELOC];
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        rd_set;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    rd_set  = s_araddr[6];
    if (s_araddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end else if (s_araddr[7] == 1'b0) begin
      rd_word[15:0] = s_araddr[5] ? desc_q[rd_set][s_araddr[4:2]] :
                                    base_q[rd_set][s_araddr[4:2]];
    end else if (s_araddr == mmr_pkg::OFS_CONTROL) begin
      rd_word[mmr_pkg::CTL_RELOC] = reloc_en_q;
    end else if (s_araddr == mmr_pkg::OFS_STATUS) begin
      rd_word[15:0] = ps_q;
    end else if (s_araddr == mmr_pkg::OFS_FAULT) begin
      rd_word[19:0] = {fault_info_q, fault_va_q};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= mmr_pkg::RESP_OKAY;
    end else begin
      s_arready <= !s_rvalid && !(s_arvalid && s_arready);
      if (s_arvalid && s_arready) begin
        s_arready <= 1'b0;
        s_rvalid  <= 1'b1;
        s_rdata   <= rd_word;
        s_rresp   <= rd_hit ? mmr_pkg::RESP_OKAY : mmr_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Address translation and protection
  // ----------------------------------------------------------------------
  logic        xl_user;
  logic [2:0]  xl_page;
  logic [15:0] xl_base;
  logic [2:0]  xl_key;
  logic [17:0] xl_pa;
  logic        xl_nonres;
  logic        xl_ro;

  always_comb begin
    xl_user = is_user(core_req.use_prev ? prev_mode : cur_mode);
    xl_page = core_req.vaddr[mmr_pkg::PAGE_SEL_LSB +: 3];
    xl_base = base_q[xl_user][xl_page];
    xl_key  = key_of(desc_q[xl_user][xl_page]);
    xl_pa = 18'({xl_base[mmr_pkg::BASE_LSB +: mmr_pkg::BASE_W], 6'h00}) +
            18'(core_req.vaddr[mmr_pkg::PAGE_SEL_LSB-1:0]);
    xl_nonres = (xl_key != mmr_pkg::KEY_READONLY) && (xl_key != mmr_pkg::KEY_FULL);
    xl_ro = (xl_key == mmr_pkg::KEY_READONLY) && core_req.write;
    if (!reloc_en_q) begin
      // With relocation off the top page still reaches the peripheral page.
      xl_pa     = (xl_page == mmr_pkg::IO_PAGE_SEL) ? {mmr_pkg::IO_PAGE_TOP, core_req.vaddr} :
                                                      {2'h0, core_req.vaddr};
      xl_nonres = 1'b0;
      xl_ro     = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_rsp_q <= '0;
    end else begin
      core_rsp_q.valid    <= core_req.valid;
      core_rsp_q.fault    <= core_req.valid && (xl_nonres || xl_ro);
      core_rsp_q.nonres   <= core_req.valid && xl_nonres;
      core_rsp_q.readonly <= core_req.valid && xl_ro;
      core_rsp_q.io_page  <= core_req.valid && (xl_pa[17:13] == 5'h1f);
      core_rsp_q.paddr    <= (xl_nonres || xl_ro) ? 18'h00000 : xl_pa;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_va_q   <= 16'h0000;
      fault_info_q <= 4'h0;
    end else if (core_req.valid && (xl_nonres || xl_ro)) begin
      fault_va_q   <= core_req.vaddr;
      fault_info_q <= {core_req.write, xl_user, xl_ro, xl_nonres};
    end
  end

  // ----------------------------------------------------------------------
  // Stack pointers
  // ----------------------------------------------------------------------
  // stack pointer by mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_q[0]    <= 16'h0000;
      sp_q[1]    <= 16'h0000;
      sp_rdata_q <= 16'h0000;
    end else begin
      if (sp_we) begin
        sp_q[is_user(cur_mode)] <= sp_wdata;
      end
      sp_rdata_q <= sp_we ? sp_wdata : sp_q[is_user(cur_mode)];
    end
  end

  // ----------------------------------------------------------------------
  // Processor status word
  // ----------------------------------------------------------------------
  // The strap is caught after release; a reset flop may only take a constant.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= boot_strap;
      strap_s2_q <= strap_s1_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_q       <= 2'h0;
      init_pending_q <= 1'b1;
    end else if (init_pending_q) begin
      settle_q <= settle_q + 2'h1;
      if (settle_q == mmr_pkg::STRAP_SETTLE) begin
        init_pending_q <= 1'b0;
      end
    end
  end

  logic [15:0] ps_d;

  always_comb begin
    ps_d = ps_q;
    case (ps_op)
      mmr_pkg::PS_NONE: begin
        ps_d = ps_q;
      end
      mmr_pkg::PS_TRAP: begin
        ps_d = ps_src;
        ps_d[mmr_pkg::PS_PREV_LSB +: 2] = cur_mode;
      end
      mmr_pkg::PS_RETURN: begin
        ps_d = ps_src;
        if (is_user(cur_mode)) begin
          ps_d[15:12] = ps_q[15:12];
          ps_d[mmr_pkg::PS_PRI_LSB +: 3] = ps_q[mmr_pkg::PS_PRI_LSB +: 3];
        end
      end
      mmr_pkg::PS_MOVE: begin
        if (is_user(cur_mode)) begin
          ps_d[3:0] = ps_src[3:0];
        end else begin
          ps_d = ps_src;
          ps_d[mmr_pkg::PS_TRAP_BIT] = ps_q[mmr_pkg::PS_TRAP_BIT];
        end
        ps_d[mmr_pkg::PS_CUR_LSB +: 2] = cur_mode;
      end
      mmr_pkg::PS_EXPLICIT: begin
        ps_d = ps_src;
        if (is_user(cur_mode)) begin
          ps_d[mmr_pkg::PS_TRAP_BIT] = ps_q[mmr_pkg::PS_TRAP_BIT];
        end
      end
      default: begin
        ps_d = ps_q;
      end
    endcase
    if (init_pending_q && (settle_q == mmr_pkg::STRAP_SETTLE)) begin
      ps_d[mmr_pkg::PS_PRI_LSB +: 3] = strap_s2_q ? mmr_pkg::PRI_BOOT : mmr_pkg::PRI_CLEAR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ps_q      <= mmr_pkg::RST_STATUS;
      ps_word_q <= mmr_pkg::RST_STATUS;
    end else begin
      ps_q      <= ps_d;
      ps_word_q <= ps_d;
    end
  end

endmodule

//--- testbench/mmr_properties.sv
// Checker on the core reference and status word ports of mmr_top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module mmr_properties (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Core ports
  input wire mmr_pkg::mmr_req_t   core_req,
  input wire mmr_pkg::mmr_rsp_t   core_rsp_q,
  input wire mmr_pkg::mmr_ps_op_t ps_op,
  input wire logic [15:0]         ps_src,
  input wire logic [15:0]         ps_word_q,
  // Start strap
  input wire logic                boot_strap
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ----------------
  // Sequences
  // ----------------
  sequence s_abort;
    core_rsp_q.valid && core_rsp_q.fault;
  endsequence

  // The strap must stay put while it is synchronised, or the priority is undefined.
  sequence s_boot_release;
    $rose(aresetn) && boot_strap ##1 boot_strap [*5];
  endsequence

  // ----------------
  // Properties
  // ----------------
  a_rsp_next_cycle:
    assert property (core_req.valid |=> core_rsp_q.valid) else $error("reference unanswered");
  a_abort_no_addr:
    assert property (s_abort |-> core_rsp_q.paddr == 18'h00000) else $error("abort has address");
  a_nonres_aborts:
    assert property (core_rsp_q.valid && core_rsp_q.nonres |-> core_rsp_q.fault)
      else $error("nonresident access passed");
  a_ro_write_only:
    assert property (s_abort ##0 core_rsp_q.readonly |-> $past(core_req.write))
      else $error("read aborted on read-only page");
  a_trap_copy:
    assert property (ps_op == mmr_pkg::PS_TRAP |=> ps_word_q ==
      {$past(ps_src[15:14]), $past(ps_word_q[15:14]), $past(ps_src[11:0])})
      else $error("trap did not record previous mode");
  a_move_keep_mode:
    assert property (ps_op == mmr_pkg::PS_MOVE |=> $stable(ps_word_q[15:14]))
      else $error("move changed current mode");
  a_power_up_kernel:
    assert property ($rose(aresetn) |-> ps_word_q[15:14] == mmr_pkg::MODE_KERNEL)
      else $error("not kernel after reset");
  a_boot_priority:
    assert property (s_boot_release |-> ps_word_q[7:5] == mmr_pkg::PRI_BOOT)
      else $error("boot priority not set");
endmodule

bind mmr_top mmr_properties u_props (
  .aclk(aclk), .aresetn(aresetn), .core_req(core_req), .core_rsp_q(core_rsp_q),
  .ps_op(ps_op), .ps_src(ps_src), .ps_word_q(ps_word_q), .boot_strap(boot_strap)
);

//--- testbench/mmr_core_model.sv
// Behavioural core: one-cycle references, status word commands and stack writes.
// Assumes the unit answers one cycle after each request, on the same clock.
`timescale 1ns/1ps

module mmr_core_model (
  // Clock
  input wire logic                aclk,
  // Reference port
  output mmr_pkg::mmr_req_t       core_req,
  input wire mmr_pkg::mmr_rsp_t   core_rsp_q,
  // Status word and stack port
  output mmr_pkg::mmr_ps_op_t     ps_op,
  output logic [15:0]             ps_src,
  output logic                    sp_we,
  output logic [15:0]             sp_wdata
);
  initial begin
    core_req = '0;
    ps_op = mmr_pkg::PS_NONE;
    ps_src = 16'h0000;
    sp_we = 1'b0;
    sp_wdata = 16'h0000;
  end

  // Idle lines carry the inverse of the last value so stale data cannot pass.
  task automatic ref_mem(input logic wr, input logic pv, input logic [15:0] va,
                         output mmr_pkg::mmr_rsp_t rsp);
    core_req <= {1'b1, wr, pv, va};
    @(posedge aclk);
    core_req <= {1'b0, ~wr, ~pv, ~va};
    @(posedge aclk);
    rsp = core_rsp_q;
  endtask

  task automatic ps_cmd(input mmr_pkg::mmr_ps_op_t op, input logic [15:0] src);
    ps_op <= op;
    ps_src <= src;
    @(posedge aclk);
    ps_op <= mmr_pkg::PS_NONE;
    ps_src <= ~src;
    @(posedge aclk);
  endtask

  task automatic sp_write(input logic [15:0] d);
    sp_we <= 1'b1;
    sp_wdata <= d;
    @(posedge aclk);
    sp_we <= 1'b0;
    sp_wdata <= ~d;
    @(posedge aclk);
  endtask
endmodule

//--- testbench/testbench.sv
// Bench for mmr_top: AXI4-Lite register tasks, core references, status commands.
// Assumes mmr_core_model on the core ports and the bound property checker.
`timescale 1ns/1ps

module testbench;
  localparam logic [1:0] OK  = mmr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = mmr_pkg::RESP_SLVERR;
  logic                aclk = 1'b0, aresetn = 1'b0, boot_strap = 1'b1;
  logic                s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic                s_arvalid = 1'b0, s_rready = 1'b0;
  logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid, sp_we;
  logic [7:0]          s_awaddr = 8'h00, s_araddr = 8'h00;
  logic [31:0]         s_wdata = 32'h0, s_rdata;
  logic [3:0]          s_wstrb = 4'h0;
  logic [1:0]          s_bresp, s_rresp;
  logic [15:0]         ps_src, ps_word_q, sp_wdata, sp_rdata_q;
  mmr_pkg::mmr_req_t   core_req;
  mmr_pkg::mmr_rsp_t   core_rsp_q, rsp;
  mmr_pkg::mmr_ps_op_t ps_op;
  int                  num_errors = 0, n_checks = 0;

  always #10 aclk = ~aclk;

  mmr_top dut (
    .aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .core_req(core_req),
    .core_rsp_q(core_rsp_q), .ps_op(ps_op), .ps_src(ps_src), .ps_word_q(ps_word_q),
    .sp_we(sp_we), .sp_wdata(sp_wdata), .sp_rdata_q(sp_rdata_q), .boot_strap(boot_strap)
  );
  mmr_core_model core (
    .aclk(aclk), .core_req(core_req), .core_rsp_q(core_rsp_q), .ps_op(ps_op),
    .ps_src(ps_src), .sp_we(sp_we), .sp_wdata(sp_wdata)
  );

  // ----------------
  // Tasks
  // ----------------
  task automatic stop_test;
    if (num_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Address and data are offered together; no latency is assumed, only a bound.
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
    bit aw = 1'b0;
    bit w = 1'b0;
    bit got = 1'b0;
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= {16'h0000, d};
    s_wstrb <= 4'h3;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge aclk);
      if (!aw && s_awready) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w && s_wready) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
      if (s_bvalid) begin
        got = 1'b1;
        chk({30'h0, s_bresp}, {30'h0, er});
      end
    end
    if (!got) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ar = 1'b0;
    bit got = 1'b0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (int n = 0; n < 40 && !got; n++) begin
      @(posedge aclk);
      if (!ar && s_arready) begin
        ar = 1'b1;
        s_arvalid <= 1'b0;
      end
      if (s_rvalid) begin
        got = 1'b1;
        chk(s_rdata, exp);
        chk({30'h0, s_rresp}, {30'h0, er});
      end
    end
    if (!got) begin
      num_errors++;
      stop_test();
    end
  endtask

  function automatic logic [17:0] pa(input logic [11:0] b, input logic [15:0] va);
    return {b, 6'h00} + {5'h00, va[12:0]};
  endfunction

  task automatic ref_chk(input logic w, input logic pv, input logic [15:0] va,
                         input logic ef, input logic [17:0] ep);
    core.ref_mem(w, pv, va, rsp);
    chk({12'h000, rsp.valid, rsp.fault, rsp.paddr}, {12'h000, 1'b1, ef, ep});
  endtask

  task automatic ps_chk(input mmr_pkg::mmr_ps_op_t op, input logic [15:0] s, input logic [15:0] e);
    core.ps_cmd(op, s);
    chk({16'h0000, ps_word_q}, {16'h0000, e});
  endtask

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({16'h0000, ps_word_q}, 32'h0000_00e0);
    rd(8'h44, {16'h0000, mmr_pkg::RST_PAGE_REG}, OK);
    rd(8'h8c, 32'h0, ERR);
    rd(8'h02, 32'h0, ERR);
    wr(8'h84, 16'hffff, ERR);
    wr(8'h00, 16'ha123, OK);
    wr(8'h20, 16'h0004, OK);
    wr(8'h04, 16'h0001, OK);
    wr(8'h24, 16'h0002, OK);
    wr(8'h1c, 16'h0f80, OK);
    wr(8'h3c, 16'h0004, OK);
    wr(8'h40, 16'h0123, OK);
    wr(8'h60, 16'h0002, OK);
    wr(8'h80, 16'h0001, OK);
    rd(8'h00, 32'h0000_a123, OK);
    ref_chk(1'b0, 1'b0, 16'h0042, 1'b0, pa(12'h123, 16'h0042));
    ref_chk(1'b1, 1'b0, 16'h1fff, 1'b0, pa(12'h123, 16'h1fff));
    ref_chk(1'b0, 1'b0, 16'h2010, 1'b0, pa(12'h001, 16'h2010));
    ref_chk(1'b1, 1'b0, 16'h2010, 1'b1, 18'h00000);
    ref_chk(1'b0, 1'b0, 16'h4000, 1'b1, 18'h00000);
    ref_chk(1'b0, 1'b0, 16'he004, 1'b0, pa(12'hf80, 16'he004));
    chk({31'h0, rsp.io_page}, 32'h1);
    core.sp_write(16'h2222);
    chk({16'h0000, sp_rdata_q}, 32'h0000_2222);
    ps_chk(mmr_pkg::PS_TRAP, 16'hc000, 16'hc000);
    ref_chk(1'b0, 1'b0, 16'h0042, 1'b0, pa(12'h123, 16'h0042));
    ref_chk(1'b1, 1'b0, 16'h0042, 1'b1, 18'h00000);
    ref_chk(1'b0, 1'b0, 16'h2010, 1'b1, 18'h00000);
    rd(8'h88, 32'h0005_2010, OK);
    ref_chk(1'b1, 1'b1, 16'h0042, 1'b0, pa(12'h123, 16'h0042));
    core.sp_write(16'h1111);
    chk({16'h0000, sp_rdata_q}, 32'h0000_1111);
    ps_chk(mmr_pkg::PS_RETURN, 16'h00ef, 16'hc00f);
    ps_chk(mmr_pkg::PS_MOVE, 16'h3fe5, 16'hc005);
    ps_chk(mmr_pkg::PS_TRAP, 16'h0000, 16'h3000);
    // The stack output follows a mode change one cycle late.
    @(posedge aclk);
    chk({16'h0000, sp_rdata_q}, 32'h0000_2222);
    ps_chk(mmr_pkg::PS_EXPLICIT, 16'h30ef, 16'h30ef);
    ps_chk(mmr_pkg::PS_MOVE, 16'hc000, 16'h0000);
    for (int i = 1; i < 3; i++) begin
      ps_chk(mmr_pkg::PS_EXPLICIT, {i[1:0], 14'h0}, {i[1:0], 14'h0});
      ref_chk(1'b1, 1'b0, 16'h0042, 1'b0, pa(12'h123, 16'h0042));
      chk({16'h0000, sp_rdata_q}, 32'h0000_2222);
    end
    ps_chk(mmr_pkg::PS_EXPLICIT, 16'h0000, 16'h0000);
    wr(8'h80, 16'h0000, OK);
    chk({16'h0000, sp_rdata_q}, 32'h0000_2222);
    ps_chk(mmr_pkg::PS_EXPLICIT, 16'hc000, 16'hc000);
    ref_chk(1'b0, 1'b0, 16'he004, 1'b0, {2'h3, 16'he004});
    chk({16'h0000, sp_rdata_q}, 32'h0000_1111);
    // A second power-up, now towards the monitor, must clear mode and priority.
    aresetn <= 1'b0;
    boot_strap <= 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({16'h0000, ps_word_q}, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000, OK);
    stop_test();
  end
endmodule
